// ==== hdl/bsq_sequencer.sv ====
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module bsq_sequencer #(
    parameter int SS_CYC    = bsq_pkg::SS_RAMP_CYC,
    parameter int DELAY_CYC = bsq_pkg::START_DELAY_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        phase_clk_pulse,
    input  wire logic        supply_good,
    input  wire logic        lock_ok,
    input  wire logic        sync_pulse,
    input  wire logic        enable_in,
    input  wire logic        modulator_pulse,
    input  wire logic        out_above_target,
    input  wire logic        out_above_113,
    input  wire logic        out_above_120,
    input  wire logic        out_below_87,
    input  wire logic        out_in_window,
    input  wire logic        out_below_uv,
    input  wire logic        temp_above_150,
    input  wire logic        temp_below_125,
    input  wire logic        phase_oc_trip,
    input  wire logic        share_bus_oc,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             enable_out,
    output logic             enable_oe_n,
    output logic             enable_sink_on,
    output logic             high_side_drive,
    output logic             low_side_drive,
    output logic             power_ok_flag,
    output logic             soft_start_active,
    output logic      [11:0] soft_start_level
);
    ////////////////////////////////////////////////////////////////////////
    // reset release: two flops, rest of design uses rst_n
    logic rst_meta_q;                 // first stage
    logic rst_n;                      // released reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    bsq_pkg::bsq_state_type st_q, st_d;
    logic [11:0] cnt_q, cnt_d;        // delay / ramp / hiccup counter
    logic [1:0]  hic_q, hic_d;        // hiccup interval index
    logic        ov_latch_q, ov_latch_d;   // latched overvoltage
    logic        ot_q, ot_d;          // over-temperature held
    logic [2:0]  oc_cnt_q, oc_cnt_d;  // per-phase trip qualify
    logic [3:0]  sync_cnt_q, sync_cnt_d;   // missing-sync count
    logic        sync_lost_q, sync_lost_d;
    logic [1:0]  pg_cnt_q, pg_cnt_d;  // power-ok fault filter
    logic        pg_q, pg_d;
    logic        first_q, first_d;    // first switching cycle pending
    logic        gate_q, gate_d;      // modulator passed through
    logic        crow_q, crow_d;      // non-latched low-side crowbar
    logic        hs_q, hs_d, ls_q, ls_d;
    logic        en_pull_q, en_pull_d;  // own pull-down of enable
    logic        sink_q, sink_d, ssa_q, ssa_d;
    logic        sw_en_q, sw_en_d;    // software enable
    logic [4:0]  flt_q, flt_d;        // sticky fault record
    logic [31:0] rd_q, rd_d;
    logic        wait_q, wait_d;

    // derived conditions
    logic oc_decl;                    // declared overcurrent
    logic ready;                      // start conditions met
    logic ext_low;                    // enable held low by another
    logic fault_pull;

    // ext_low only counts when we are not pulling the line ourselves
    assign ext_low = !enable_in && !en_pull_q;
    assign oc_decl = (oc_cnt_q == 3'(bsq_pkg::OC_DELAY_CYC))
                     || share_bus_oc;
    assign ready = supply_good && lock_ok && !sync_lost_q && enable_in
                   && sw_en_q;
    assign fault_pull = ov_latch_q || ot_q || (st_q == bsq_pkg::BSQ_HICCUP);

    ////////////////////////////////////////////////////////////////////////
    // protection detectors
    always_comb begin
        ot_d = ot_q;
        if (temp_above_150) begin
            ot_d = 1'b1;
        end else if (temp_below_125) begin
            ot_d = 1'b0;
        end
        // trip plus seven further cycles
        oc_cnt_d = 3'h0;
        if (phase_oc_trip && oc_cnt_q != 3'(bsq_pkg::OC_DELAY_CYC)) begin
            oc_cnt_d = oc_cnt_q + 3'h1;
        end else if (phase_oc_trip) begin
            oc_cnt_d = oc_cnt_q;
        end
        // sync watchdog
        sync_cnt_d  = sync_pulse ? 4'h0 : sync_cnt_q;
        sync_lost_d = sync_lost_q;
        if (!sync_pulse && sync_cnt_q != 4'(bsq_pkg::SYNC_LOSS_CYC)) begin
            sync_cnt_d = sync_cnt_q + 4'h1;
        end
        if (sync_cnt_q == 4'(bsq_pkg::SYNC_LOSS_CYC)) begin
            sync_lost_d = 1'b1;
        end else if (lock_ok && sync_pulse) begin
            sync_lost_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        hic_d = hic_q;
        ov_latch_d = ov_latch_q;
        first_d = first_q;
        gate_d = gate_q;
        crow_d = crow_q;
        case (st_q)
            bsq_pkg::BSQ_OFF: begin
                cnt_d = 12'h000;
                if (ready) begin
                    st_d = bsq_pkg::BSQ_DELAY;
                end
            end
            bsq_pkg::BSQ_DELAY: begin
                if (phase_clk_pulse) begin
                    cnt_d = cnt_q + 12'h001;
                end
                if (cnt_q == 12'(DELAY_CYC)) begin
                    st_d  = bsq_pkg::BSQ_PREWAIT;
                    cnt_d = 12'h000;
                end
            end
            bsq_pkg::BSQ_PREWAIT: begin
                if (out_above_120) begin
                    ov_latch_d = 1'b1;
                    st_d = bsq_pkg::BSQ_LATCHED;
                end else if (!out_above_target) begin
                    st_d = bsq_pkg::BSQ_RAMP;
                    first_d = 1'b1;
                    gate_d  = 1'b0;
                end
            end
            bsq_pkg::BSQ_RAMP: begin
                if (phase_clk_pulse) begin
                    cnt_d = cnt_q + 12'h001;
                end
                if (modulator_pulse) begin
                    gate_d = 1'b1;
                end
                if (gate_q && phase_clk_pulse) begin
                    first_d = 1'b0;
                end
                if (cnt_q == 12'(SS_CYC)) begin
                    st_d = bsq_pkg::BSQ_RUN;
                end
            end
            bsq_pkg::BSQ_RUN: begin
                cnt_d = 12'(SS_CYC);
            end
            bsq_pkg::BSQ_HICCUP: begin
                // wait three soft-start intervals, then retry
                if (phase_clk_pulse) begin
                    cnt_d = cnt_q + 12'h001;
                end
                if (cnt_q == 12'(SS_CYC)) begin
                    cnt_d = 12'h000;
                    hic_d = hic_q + 2'h1;
                    if (hic_q == 2'(bsq_pkg::HICCUP_SS_INTV - 1)) begin
                        st_d = bsq_pkg::BSQ_OFF;
                        hic_d = 2'h0;
                    end
                end
            end
            bsq_pkg::BSQ_LATCHED: begin
                st_d = bsq_pkg::BSQ_LATCHED;  // only reset leaves this state
            end
            default: begin
                st_d = bsq_pkg::BSQ_OFF;
            end
        endcase
        // overvoltage active from start of soft-start
        if ((st_q == bsq_pkg::BSQ_RAMP || st_q == bsq_pkg::BSQ_RUN)
            && out_above_120) begin
            ov_latch_d = 1'b1;
            st_d = bsq_pkg::BSQ_LATCHED;
        end
        // overcurrent takes precedence over the normal run path
        if (!ov_latch_q && oc_decl && (st_q == bsq_pkg::BSQ_RAMP
            || st_q == bsq_pkg::BSQ_RUN)) begin
            st_d = bsq_pkg::BSQ_HICCUP;
            cnt_d = 12'h000;
        end
        // any lost condition except lock_ok resets soft-start at once
        if (st_q != bsq_pkg::BSQ_LATCHED && st_q != bsq_pkg::BSQ_HICCUP
            && st_q != bsq_pkg::BSQ_OFF && !ov_latch_d
            && (!supply_good || !enable_in || sync_lost_q || ot_q
                || !sw_en_q)) begin
            st_d = bsq_pkg::BSQ_OFF;
            cnt_d = 12'h000;
        end
        // crowbar hiccup when enable low and over 113%
        if (out_above_113 && !enable_in) begin
            crow_d = 1'b1;
        end else if (out_below_87) begin
            crow_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gate drives, enable line, power-ok
    always_comb begin
        hs_d = 1'b0;
        ls_d = 1'b0;
        if (ov_latch_q) begin
            // high side off for good; low side until below 87%
            ls_d = ls_q && !out_below_87;
            if (st_q != bsq_pkg::BSQ_LATCHED) begin
                ls_d = 1'b1;
            end
        end else if (st_q == bsq_pkg::BSQ_RAMP
                     || st_q == bsq_pkg::BSQ_RUN) begin
            if (gate_q && first_q) begin
                ls_d = 1'b1;
            end else if (gate_q) begin
                hs_d = modulator_pulse;
                ls_d = !modulator_pulse;
            end
        end else if (crow_q) begin
            ls_d = 1'b1;
        end
        // drop high side the same cycle conditions vanish; low side too unless crowbar or overvoltage
        if (!supply_good || oc_decl || !enable_in) begin
            hs_d = 1'b0;
            if (!crow_q && !ov_latch_q) begin
                ls_d = 1'b0;
            end
        end
        if (ov_latch_d && !ov_latch_q) begin
            hs_d = 1'b0;
            ls_d = 1'b1;
        end
        en_pull_d = fault_pull || oc_decl || ov_latch_d;
        sink_d    = !(st_d == bsq_pkg::BSQ_RAMP
                      || st_d == bsq_pkg::BSQ_RUN);
        ssa_d     = (st_d == bsq_pkg::BSQ_RAMP);
        // power-ok filter
        pg_d = pg_q;
        pg_cnt_d = 2'h0;
        if (st_q == bsq_pkg::BSQ_RUN && !pg_q && out_in_window) begin
            pg_d = 1'b1;
        end
        if (pg_q && (!out_in_window || (out_below_uv && !ot_q
                     && !oc_decl && !sync_lost_q))) begin
            pg_cnt_d = pg_cnt_q + 2'h1;
            if (pg_cnt_q == 2'(bsq_pkg::POWER_OK_FLAG_FILT_CYC - 1)) begin
                pg_d = 1'b0;
                pg_cnt_d = 2'h0;
            end
        end
        if (st_d != bsq_pkg::BSQ_RUN || ov_latch_q || !enable_in) begin
            pg_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state, reads show live state
    always_comb begin
        sw_en_d = sw_en_q;
        flt_d   = flt_q | {sync_lost_q, (st_q == bsq_pkg::BSQ_LATCHED
                  && st_q != bsq_pkg::BSQ_RUN && out_above_120),
                  oc_decl, ot_q, ov_latch_q};
        rd_d    = 32'h0000_0000;
        wait_d  = 1'b1;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;            // answer next cycle
            if (avs_write && avs_address == bsq_pkg::ADDR_CTRL) begin
                sw_en_d = avs_writedata[bsq_pkg::CTRL_SW_EN_BIT];
            end
            if (avs_write && avs_address == bsq_pkg::ADDR_FAULT) begin
                // set wins over clear, except bit 3 (FLT_PRE_BIT), where clear wins
                flt_d = (flt_q & ~avs_writedata[4:0]) | {sync_lost_q,
                        1'b0, oc_decl, ot_q, ov_latch_q};
            end
            case (avs_address)
                bsq_pkg::ADDR_CTRL:    rd_d = {31'h0, sw_en_q};
                bsq_pkg::ADDR_STATUS:  rd_d = {24'h0, pg_q, en_pull_q,
                                             enable_in, 2'h0, st_q};
                bsq_pkg::ADDR_FAULT:   rd_d = {27'h0, flt_q};
                bsq_pkg::ADDR_SSCOUNT: rd_d = {20'h0, cnt_q};
                default:               rd_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= bsq_pkg::BSQ_OFF;
            cnt_q <= 12'h000;
            hic_q <= 2'h0;
            ov_latch_q <= 1'b0;
            ot_q <= 1'b0;
            oc_cnt_q <= 3'h0;
            sync_cnt_q <= 4'h0;
            sync_lost_q <= 1'b0;
            pg_cnt_q <= 2'h0;
            pg_q <= 1'b0;
            first_q <= 1'b0;
            gate_q <= 1'b0;
            crow_q <= 1'b0;
            hs_q <= 1'b0;
            ls_q <= 1'b0;
            en_pull_q <= 1'b0;
            sink_q <= 1'b1;
            ssa_q <= 1'b0;
            sw_en_q <= bsq_pkg::CTRL_SW_EN_RST;
            flt_q <= 5'h00;
            rd_q <= 32'h0000_0000;
            wait_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hic_q <= hic_d;
            ov_latch_q <= ov_latch_d;
            ot_q <= ot_d;
            oc_cnt_q <= oc_cnt_d;
            sync_cnt_q <= sync_cnt_d;
            sync_lost_q <= sync_lost_d;
            pg_cnt_q <= pg_cnt_d;
            pg_q <= pg_d;
            first_q <= first_d;
            gate_q <= gate_d;
            crow_q <= crow_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
            en_pull_q <= en_pull_d;
            sink_q <= sink_d;
            ssa_q <= ssa_d;
            sw_en_q <= sw_en_d;
            flt_q <= flt_d;
            rd_q <= rd_d;
            wait_q <= wait_d;
        end
    end

    // outputs straight from flops, apart from the constant enable_out and the inverted enable_oe_n
    assign high_side_drive   = hs_q;
    assign low_side_drive    = ls_q;
    assign power_ok_flag     = pg_q;
    assign enable_out        = 1'b0;        // open drain drives low only
    assign enable_oe_n       = !en_pull_q;
    assign enable_sink_on    = sink_q;
    assign soft_start_active = ssa_q;
    assign soft_start_level  = cnt_q;
    assign avs_readdata      = rd_q;
    assign avs_waitrequest   = wait_q;
endmodule : bsq_sequencer

// ==== hdl/bsq_pkg.sv ====
package bsq_pkg;
    // register map (word offsets are byte addresses)
    localparam logic [3:0] ADDR_CTRL    = 4'h0; // control
    localparam logic [3:0] ADDR_STATUS  = 4'h4; // status
    localparam logic [3:0] ADDR_FAULT   = 4'h8; // sticky faults
    localparam logic [3:0] ADDR_SSCOUNT = 4'hC; // soft-start count
    // control field positions
    localparam int CTRL_SW_EN_BIT = 0;
    localparam logic CTRL_SW_EN_RST = 1'b1;
    // fault field positions
    localparam int FLT_OV_BIT  = 0;
    localparam int FLT_OT_BIT  = 1;
    localparam int FLT_OC_BIT  = 2;
    localparam int FLT_PRE_BIT = 3;
    localparam int FLT_LOCK_BIT = 4;
    // timing counts: delay and ramp in phase-clock cycles, filters in ref_clk cycles
    localparam int START_DELAY_CYC = 384;
    localparam int SS_RAMP_CYC     = 2560;
    localparam int HICCUP_SS_INTV  = 3;
    localparam int POWER_OK_FLAG_FILT_CYC  = 3;
    localparam int OC_DELAY_CYC    = 7;
    localparam int SYNC_LOSS_CYC   = 13;
    // top-level states
    typedef enum logic [2:0] {
        BSQ_OFF     = 3'b000,
        BSQ_DELAY   = 3'b001,
        BSQ_PREWAIT = 3'b010,
        BSQ_RAMP    = 3'b011,
        BSQ_RUN     = 3'b100,
        BSQ_HICCUP  = 3'b101,
        BSQ_LATCHED = 3'b110
    } bsq_state_type;
endpackage : bsq_pkg

// ==== verif/bsq_sequencer_sva.sv ====
`timescale 1ns/1ps
module bsq_sequencer_sva (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic supply_good,
    input wire logic enable_in,
    input wire logic out_in_window,
    input wire logic out_above_120,
    input wire logic temp_above_150,
    input wire logic phase_oc_trip,
    input wire logic share_bus_oc,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic enable_oe_n,
    input wire logic enable_sink_on,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic power_ok_flag,
    input wire logic soft_start_active
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // overvoltage seen once switching has started
    sequence ov_hit;
        $rose(out_above_120) && (soft_start_active || power_ok_flag);
    endsequence
    // per-phase trip with no other fault around it
    sequence oc_start;
        $rose(phase_oc_trip) && enable_oe_n && !share_bus_oc
            && !temp_above_150;
    endsequence
    // power-ok high and the window just lost
    sequence pok_blip;
        power_ok_flag && enable_in && $fell(out_in_window);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    a_sink_off_run: assert property (soft_start_active || power_ok_flag
        |-> !enable_sink_on) else $error("enable sink on while running");
    a_supply_drop_off: assert property (!supply_good
        |-> ##[1:2] (!high_side_drive && !low_side_drive))
        else $error("drives on without supply");
    a_pok_ramp_low: assert property (soft_start_active
        |-> !power_ok_flag) else $error("power ok during ramp");
    a_pok_enable_low: assert property ($fell(enable_in)
        |-> ##[1:4] !power_ok_flag) else $error("power ok kept on disable");
    a_pok_filter_hold: assert property (pok_blip
        |=> power_ok_flag) else $error("power ok dropped too early");
    a_pok_window_drop: assert property (!out_in_window [*5]
        |-> !power_ok_flag) else $error("power ok kept outside window");
    a_ov_latch_off: assert property (ov_hit |-> ##[1:4]
        (!high_side_drive && !enable_oe_n && !power_ok_flag))
        else $error("overvoltage not latched");
    a_temp_pull_en: assert property (temp_above_150
        |-> ##[1:2] !enable_oe_n) else $error("hot but enable released");
    a_oc_share_pull: assert property ($rose(share_bus_oc)
        && (soft_start_active || power_ok_flag) |-> ##[1:2]
        (!enable_oe_n && !high_side_drive && !low_side_drive))
        else $error("share bus overcurrent ignored");
    a_oc_delay_wait: assert property (oc_start
        |-> enable_oe_n [*6]) else $error("overcurrent declared early");
endmodule : bsq_sequencer_sva

bind bsq_sequencer bsq_sequencer_sva u_bsq_sequencer_sva (.*);

// ==== verif/bsq_companion.sv ====
`timescale 1ns/1ps
// companion module on the shared enable line, pull-up outside
module bsq_companion (
    input  wire logic ref_clk,
    input  wire logic dev_oe_n,
    input  wire logic sys_en,
    input  wire logic fault_cmd,
    input  wire logic slow,
    output logic      en_line,
    output logic      peer_off
);
    logic [7:0] hold_q = 8'h00; // release delay of a slow companion
    // a slow companion keeps pulling a while after its fault clears
    always_ff @(posedge ref_clk) begin
        if (fault_cmd)
            hold_q <= 8'h09;
        else if (hold_q != 8'h00 && slow)
            hold_q <= hold_q - 8'h01;
        else
            hold_q <= 8'h00;
    end
    // wired-or: any puller wins over the pull-up
    assign en_line  = sys_en & dev_oe_n & !fault_cmd & (hold_q == 8'h00);
    assign peer_off = !en_line;
endmodule : bsq_companion

// ==== verif/bsq_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module bsq_sequencer_tb_top;
    localparam int SS = 20, DLY = 8, LIMIT = 20000; // shortened counts
    logic ref_clk = 1'b0, arst_n = 1'b0, phase_clk_pulse = 1'b0;
    logic supply_good = 1'b0, lock_ok = 1'b0, sync_pulse = 1'b0;
    logic modulator_pulse = 1'b0, out_above_113 = 1'b0, out_above_120 = 1'b0;
    logic out_below_87 = 1'b0, out_in_window = 1'b1, out_below_uv = 1'b0;
    logic temp_above_150 = 1'b0, temp_below_125 = 1'b1, phase_oc_trip = 1'b0;
    logic share_bus_oc = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, enable_out, enable_oe_n, enable_sink_on, en_line;
    logic high_side_drive, low_side_drive, power_ok_flag, soft_start_active;
    logic sys_en = 1'b0, fault_cmd = 1'b0, slow = 1'b0, sync_run = 1'b1;
    logic mod_run = 1'b0, out_above_target = 1'b0;
    logic [11:0] soft_start_level;
    logic [1:0] ph_q = 2'h0;
    int n_fail = 0, n_compared = 0, cyc = 0, n_ph = 0, t0, seed;
    ////////////////////////////////////////////////////////////////////////
    bsq_sequencer #(.SS_CYC(SS), .DELAY_CYC(DLY)) u_bsq_sequencer (
        .ref_clk(ref_clk), .arst_n(arst_n), .phase_clk_pulse(phase_clk_pulse),
        .supply_good(supply_good), .lock_ok(lock_ok), .sync_pulse(sync_pulse),
        .enable_in(en_line), .modulator_pulse(modulator_pulse),
        .out_above_target(out_above_target), .out_above_113(out_above_113),
        .out_above_120(out_above_120), .out_below_87(out_below_87),
        .out_in_window(out_in_window), .out_below_uv(out_below_uv),
        .temp_above_150(temp_above_150), .temp_below_125(temp_below_125),
        .phase_oc_trip(phase_oc_trip), .share_bus_oc(share_bus_oc),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .enable_out(enable_out),
        .enable_oe_n(enable_oe_n), .enable_sink_on(enable_sink_on),
        .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
        .power_ok_flag(power_ok_flag), .soft_start_active(soft_start_active),
        .soft_start_level(soft_start_level));
    bsq_companion u_bsq_companion (.ref_clk(ref_clk), .dev_oe_n(enable_oe_n),
        .sys_en(sys_en), .fault_cmd(fault_cmd), .slow(slow),
        .en_line(en_line), .peer_off());
    ////////////////////////////////////////////////////////////////////////
    always #10 ref_clk = ~ref_clk; // 50 MHz
    // phase pulse and sync every fourth cycle, random modulator
    always @(posedge ref_clk) begin
        ph_q <= ph_q + 2'h1;
        phase_clk_pulse <= (ph_q == 2'h3);
        sync_pulse <= (ph_q == 2'h3) & sync_run;
        modulator_pulse <= mod_run & 1'($urandom_range(1, 0));
        n_ph <= n_ph + int'(phase_clk_pulse);
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // pulse count in range: cannot come early, little slack late
    function automatic logic span_ok(input int got, input int lo);
        return got >= lo && got <= lo + 2;
    endfunction : span_ok
    function automatic logic pick(input int w);
        return (w == 0) ? power_ok_flag : soft_start_active;
    endfunction : pick
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : tick
    // bounded wait, settles at a falling edge
    task automatic wait_for(input int w, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && pick(w) !== v; i++) @(negedge ref_clk);
        chk(pick(w), v);
    endtask : wait_for
    // one avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(i < 50, 1'b1);
    endtask : bus
    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // start from ready inputs; drives wait for the modulator
    task automatic power_up;
        @(posedge ref_clk);
        supply_good <= 1'b1;
        lock_ok <= 1'b1;
        sys_en <= 1'b1;
        mod_run <= 1'b0;
        t0 = n_ph;
        wait_for(1, 1'b1, 2000);
        chk(span_ok(n_ph - t0, DLY), 1'b1);
        tick(6);
        chk({high_side_drive, low_side_drive}, 2'b00);
        @(posedge ref_clk);
        mod_run <= 1'b1;
        wait_for(0, 1'b1, 2000);
        chk(n_ph - t0 >= DLY + SS, 1'b1);
    endtask : power_up
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = $urandom(27);
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        tick(3);
        bus(1'b0, bsq_pkg::ADDR_CTRL, 32'h0, rd);
        chk(rd[0], bsq_pkg::CTRL_SW_EN_RST);
        bus(1'b1, 4'h2, 32'hFFFFFFFF, rd);
        bus(1'b0, 4'h2, 32'h0, rd);
        chk(rd, 32'h0);
        chk(enable_sink_on, 1'b1);
        power_up();
        // short window blips keep power-ok, a long one drops it
        repeat (4) begin
            @(posedge ref_clk);
            out_in_window <= 1'b0;
            repeat ($urandom_range(2, 1)) @(posedge ref_clk);
            out_in_window <= 1'b1;
            tick(2);
            chk(power_ok_flag, 1'b1);
        end
        @(posedge ref_clk);
        out_in_window <= 1'b0;
        tick(6);
        chk(power_ok_flag, 1'b0);
        @(posedge ref_clk);
        out_in_window <= 1'b1;
        wait_for(0, 1'b1, 100);
        bus(1'b0, bsq_pkg::ADDR_STATUS, 32'h0, rd);
        chk(rd[7:5], 3'b101);
        // companion pulls the shared line, then crowbar while low
        @(posedge ref_clk);
        fault_cmd <= 1'b1;
        slow <= 1'($urandom_range(1, 0));
        out_above_113 <= 1'b1;
        tick(5);
        chk({power_ok_flag, high_side_drive, enable_oe_n}, 3'b001);
        chk(low_side_drive, 1'b1);
        @(posedge ref_clk);
        out_above_113 <= 1'b0;
        out_below_87 <= 1'b1;
        tick(3);
        chk(low_side_drive, 1'b0);
        @(posedge ref_clk);
        out_below_87 <= 1'b0;
        fault_cmd <= 1'b0;
        wait_for(0, 1'b1, 3000);
        // over-temperature with hysteresis
        @(posedge ref_clk);
        temp_above_150 <= 1'b1;
        temp_below_125 <= 1'b0;
        tick(3);
        chk(enable_oe_n, 1'b0);
        @(posedge ref_clk);
        temp_above_150 <= 1'b0;
        tick(6);
        chk(enable_oe_n, 1'b0);
        @(posedge ref_clk);
        temp_below_125 <= 1'b1;
        tick(3);
        chk(enable_oe_n, 1'b1);
        wait_for(0, 1'b1, 3000);
        // sync lost longer than thirteen cycles, then restart
        @(posedge ref_clk);
        sync_run <= 1'b0;
        out_above_target <= 1'b1;
        tick(24);
        chk({power_ok_flag, high_side_drive}, 2'b00);
        @(posedge ref_clk);
        sync_run <= 1'b1;
        tick(80);
        chk({soft_start_active, soft_start_level}, 13'h0000);
        @(posedge ref_clk);
        out_above_target <= 1'b0;
        wait_for(0, 1'b1, 3000);
        // share bus overcurrent, hiccup, trip again during retry
        @(posedge ref_clk);
        share_bus_oc <= 1'b1;
        tick(2);
        chk(enable_oe_n, 1'b0);
        @(posedge ref_clk);
        share_bus_oc <= 1'b0;
        t0 = n_ph;
        wait_for(1, 1'b1, 3000);
        chk(n_ph - t0 >= 3 * SS, 1'b1);
        @(posedge ref_clk);
        phase_oc_trip <= 1'b1;
        tick(40);
        chk({enable_oe_n, power_ok_flag}, 2'b00);
        @(posedge ref_clk);
        phase_oc_trip <= 1'b0;
        wait_for(0, 1'b1, 5000);
        // latching overvoltage, cleared only by reset
        @(posedge ref_clk);
        out_above_120 <= 1'b1;
        tick(3);
        chk({high_side_drive, low_side_drive, enable_oe_n}, 3'b010);
        @(posedge ref_clk);
        out_above_120 <= 1'b0;
        out_below_87 <= 1'b1;
        tick(20);
        chk({low_side_drive, power_ok_flag, enable_oe_n}, 3'b000);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        sys_en <= 1'b0;
        out_below_87 <= 1'b0;
        tick(2);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        tick(3);
        power_up();
        finish_test();
    end
endmodule : bsq_sequencer_tb_top
